// *** rtl/bsaf_cfg.svh ***
// constants for the battery status alarm flags block
`ifndef BSAF_CFG_SVH
`define BSAF_CFG_SVH
`define BSAF_CFG_DEPTH 128
`define BSAF_ADR_LEN 7'h00
`define BSAF_ADR_CHK 7'h01
`define BSAF_ADR_RTA 7'h02
`define BSAF_ADR_RCA 7'h04
`define BSAF_ADR_STAT 7'h0C
`define BSAF_ADR_CYC 7'h0E
`define BSAF_ADR_ICC 7'h08
`define BSAF_ADR_FCC 7'h1A
`define BSAF_ADR_MCC 7'h1C
`define BSAF_ADR_RSV 7'h1E
`define BSAF_ADR_OVL 7'h2C
`define BSAF_ADR_LOW 7'h2E
`define BSAF_ADR_LAST 7'h2E
`define BSAF_VAL_LEN 8'h64
`define BSAF_VAL_CHK 8'h5B
`define BSAF_INIT_BIT 7
`define BSAF_TEMP_FLOOR 16'h01AE
`define BSAF_TEMP_HYST 16'h0032
`define BSAF_RSOC_FULLDIS 8'h14
`define BSAF_STAT_OCA 15
`define BSAF_STAT_TCA 14
`define BSAF_STAT_OTA 12
`define BSAF_STAT_TDA 11
`define BSAF_STAT_RCA 9
`define BSAF_STAT_RTA 8
`define BSAF_STAT_INIT 7
`define BSAF_STAT_DSG 6
`define BSAF_STAT_FC 5
`define BSAF_STAT_FD 4
`endif

// *** rtl/bsaf_pkg.sv ***
// types for the battery status alarm flags block
package bsaf_pkg;
  typedef struct packed {
    logic termRate;
    logic termTaper;
    logic overCurrent;
    logic overVoltage;
    logic charging;
    logic discharging;
    logic validCharge;
    logic maxOvercharge;
    logic allDelivered;
  } bsaf_cond_t;
  typedef struct packed {
    logic [15:0] voltage;
    logic [15:0] current;
    logic [15:0] dischargeCurrent;
    logic [15:0] temperature;
    logic [15:0] tempMax;
    logic [15:0] remainingCapacity;
    logic [15:0] timeToEmpty;
    logic [15:0] avgTimeToEmpty;
    logic [15:0] finalDischargeThreshold;
    logic [15:0] firstDischargeThreshold;
    logic [15:0] fullChargeLevel;
    logic [7:0] relativeCharge;
  } bsaf_meas_t;
  typedef struct packed {
    logic [15:0] timeAlarm;
    logic [15:0] capAlarm;
    logic [15:0] initChargeCurrent;
    logic [15:0] fastChargeCurrent;
    logic [15:0] maintCurrent;
    logic [15:0] cycleCount;
    logic [15:0] overloadLevel;
    logic [7:0] lowCapacity;
  } bsaf_param_t;
  typedef enum {LdIdle, LdRead, LdCheck, LdDone} bsaf_ld_t;
endpackage

// *** rtl/bsaf_battery_status_alarm_flags.sv ***
// battery status alarm and status bits with configuration load
`timescale 1ns/1ps
`include "bsaf_cfg.svh"
// Function
// [RULE_01] overcharged alarm follows rate or taper termination
// [RULE_02] terminate-charge alarm on any charge fault
// [RULE_03] over-temp alarm with hysteresis release
// [RULE_04] terminate-discharge alarm below final threshold
// [RULE_05] capacity alarm below programmed level
// [RULE_06] time alarm below programmed level
// [RULE_07] initialized from config bit, cleared bad load
// [RULE_08] discharging bit while not charging
// [RULE_09] fully-charged on termination, cleared below level
// [RULE_10] fully-discharged until charge reaches twenty percent
// [RULE_11] config holds length and check bytes
// [RULE_12] time and capacity alarm levels from config
// [RULE_13] initial charge current from config
// [RULE_14] fast-charge current from config
// [RULE_15] maintenance current from config
// [RULE_16] cycle counter initialised from config
// [RULE_17] overload disables end-of-discharge monitoring
// [RULE_18] first threshold drops capacity to low level
// [RULE_19] config reserved bytes hold zero
// [RULE_20] final discharge flag with overload gating
// [RULE_21] words assembled low byte first
// [RULE_22] bits refreshed from conditions on each measurement tick
module bsaf_battery_status_alarm_flags #(
  parameter int ADDR_W = 7
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic loadStart,
  input wire logic measTick,
  input wire bsaf_pkg::bsaf_cond_t cond,
  input wire bsaf_pkg::bsaf_meas_t meas,
  input wire logic [7:0] cfgData,
  output logic [ADDR_W-1:0] cfgAddr_ff,
  output logic cfgRead_ff,
  output logic [15:0] statusWord_ff,
  output bsaf_pkg::bsaf_param_t param_ff,
  output logic loadBusy_ff,
  output logic loadBad_ff,
  output logic finalDischargeFlag_ff,
  output logic overloadFlag_ff,
  output logic capacityClampReq_ff,
  output logic [15:0] capacityClampValue_ff
);

  initial begin
    if (ADDR_W < 6 || ADDR_W > 7) begin
      $error("ADDR_W must be 6 or 7");
    end
  end

  bsaf_pkg::bsaf_ld_t ldState_ff;
  logic [7:0] byteLow_ff;
  logic [7:0] statByte_ff;
  logic chkFail_ff;
  logic firstFlag_ff;
  logic otaHeld_ff;
  logic [15:0] nxt_status;
  logic [15:0] otaRelease;
  logic edvEnable;

  // config memory answers one cycle after cfgRead_ff
  always_ff @(posedge clk) begin
    if (rst) begin
      ldState_ff <= bsaf_pkg::LdIdle;
      cfgAddr_ff <= '0;
      cfgRead_ff <= 1'b0;
      loadBusy_ff <= 1'b0;
    end else if (clkEn) begin
      case (ldState_ff)
        bsaf_pkg::LdIdle: begin
          if (loadStart) begin
            ldState_ff <= bsaf_pkg::LdRead;
            cfgAddr_ff <= '0;
            cfgRead_ff <= 1'b1;
            loadBusy_ff <= 1'b1;
          end
        end
        bsaf_pkg::LdRead: begin
          cfgRead_ff <= 1'b0;
          ldState_ff <= bsaf_pkg::LdCheck;
        end
        bsaf_pkg::LdCheck: begin
          if (cfgAddr_ff == ADDR_W'(`BSAF_ADR_LAST)) begin
            ldState_ff <= bsaf_pkg::LdDone;
          end else begin
            cfgAddr_ff <= cfgAddr_ff + ADDR_W'(1);
            cfgRead_ff <= 1'b1;
            ldState_ff <= bsaf_pkg::LdRead;
          end
        end
        bsaf_pkg::LdDone: begin
          loadBusy_ff <= 1'b0;
          ldState_ff <= bsaf_pkg::LdIdle;
        end
        default: ldState_ff <= bsaf_pkg::LdIdle;
      endcase
    end
  end

  // bytes captured in LdCheck, when cfgData is valid for cfgAddr_ff
  always_ff @(posedge clk) begin
    if (rst) begin
      byteLow_ff <= 8'h00;
      statByte_ff <= 8'h00;
      chkFail_ff <= 1'b0;
      param_ff <= '0;
    end else if (clkEn) begin
      if (ldState_ff == bsaf_pkg::LdIdle && loadStart) begin
        chkFail_ff <= 1'b0;
      end else if (ldState_ff == bsaf_pkg::LdCheck) begin
        byteLow_ff <= cfgData;
        case (7'(cfgAddr_ff))
          `BSAF_ADR_LEN: if (cfgData != `BSAF_VAL_LEN) chkFail_ff <= 1'b1; // [RULE_11]
          `BSAF_ADR_CHK: if (cfgData != `BSAF_VAL_CHK) chkFail_ff <= 1'b1; // [RULE_11]
          `BSAF_ADR_RSV, `BSAF_ADR_RSV + 7'h01: if (cfgData != 8'h00) chkFail_ff <= 1'b1; // [RULE_19]
          `BSAF_ADR_STAT: statByte_ff <= cfgData; // [RULE_07]
          `BSAF_ADR_RTA + 7'h01: param_ff.timeAlarm <= {cfgData, byteLow_ff}; // [RULE_12] [RULE_21]
          `BSAF_ADR_RCA + 7'h01: param_ff.capAlarm <= {cfgData, byteLow_ff}; // [RULE_12] [RULE_21]
          `BSAF_ADR_ICC + 7'h01: param_ff.initChargeCurrent <= {cfgData, byteLow_ff}; // [RULE_13]
          `BSAF_ADR_FCC + 7'h01: param_ff.fastChargeCurrent <= {cfgData, byteLow_ff}; // [RULE_14]
          `BSAF_ADR_MCC + 7'h01: param_ff.maintCurrent <= {cfgData, byteLow_ff}; // [RULE_15]
          `BSAF_ADR_CYC + 7'h01: param_ff.cycleCount <= {cfgData, byteLow_ff}; // [RULE_16]
          `BSAF_ADR_OVL + 7'h01: param_ff.overloadLevel <= {cfgData, byteLow_ff}; // [RULE_17]
          `BSAF_ADR_LOW: param_ff.lowCapacity <= cfgData; // [RULE_18]
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      loadBad_ff <= 1'b0;
    end else if (clkEn && ldState_ff == bsaf_pkg::LdDone) begin
      loadBad_ff <= chkFail_ff;
    end
  end

  // overload and end-of-discharge flags
  assign edvEnable = !(meas.dischargeCurrent > param_ff.overloadLevel); // [RULE_17]
  always_ff @(posedge clk) begin
    if (rst) begin
      overloadFlag_ff <= 1'b0;
      finalDischargeFlag_ff <= 1'b0;
      firstFlag_ff <= 1'b0;
    end else if (clkEn && measTick) begin
      overloadFlag_ff <= !edvEnable; // [RULE_17]
      if (edvEnable && meas.voltage < meas.finalDischargeThreshold) begin
        finalDischargeFlag_ff <= 1'b1; // [RULE_20]
      end else if (cond.validCharge && meas.voltage > meas.finalDischargeThreshold) begin
        finalDischargeFlag_ff <= 1'b0; // [RULE_20]
      end
      if (edvEnable && meas.voltage < meas.firstDischargeThreshold) begin
        firstFlag_ff <= 1'b1;
      end else if (cond.validCharge && meas.voltage > meas.firstDischargeThreshold) begin
        firstFlag_ff <= 1'b0;
      end
    end
  end

  // one-cycle request on the rising edge of the first threshold flag
  always_ff @(posedge clk) begin
    if (rst) begin
      capacityClampReq_ff <= 1'b0;
      capacityClampValue_ff <= 16'h0000;
    end else if (clkEn) begin
      capacityClampReq_ff <= measTick && edvEnable && !firstFlag_ff &&
                             meas.voltage < meas.firstDischargeThreshold; // [RULE_18]
      capacityClampValue_ff <= {8'h00, param_ff.lowCapacity}; // [RULE_18]
    end
  end

  // release point is the higher of the floor and max minus hysteresis
  assign otaRelease = (meas.tempMax - `BSAF_TEMP_HYST > `BSAF_TEMP_FLOOR) ?
                      meas.tempMax - `BSAF_TEMP_HYST : `BSAF_TEMP_FLOOR;

  always_comb begin
    nxt_status = statusWord_ff;
    nxt_status[`BSAF_STAT_OCA] = !cond.discharging && (cond.termRate || cond.termTaper); // [RULE_01]
    nxt_status[`BSAF_STAT_TCA] = cond.charging && (cond.overCurrent || cond.overVoltage || // [RULE_02]
                                 otaHeld_ff || cond.termRate || cond.termTaper);
    nxt_status[`BSAF_STAT_OTA] = otaHeld_ff; // [RULE_03]
    nxt_status[`BSAF_STAT_TDA] = finalDischargeFlag_ff && meas.voltage < meas.finalDischargeThreshold; // [RULE_04]
    nxt_status[`BSAF_STAT_RCA] = meas.remainingCapacity < param_ff.capAlarm; // [RULE_05]
    nxt_status[`BSAF_STAT_RTA] = !cond.validCharge && meas.timeToEmpty < param_ff.timeAlarm && // [RULE_06]
                                 !(param_ff.timeAlarm < meas.avgTimeToEmpty);
    nxt_status[`BSAF_STAT_DSG] = !cond.charging; // [RULE_08]
    if (cond.termRate || cond.termTaper || cond.maxOvercharge) begin
      nxt_status[`BSAF_STAT_FC] = 1'b1; // [RULE_09]
    end else if (meas.remainingCapacity < meas.fullChargeLevel) begin
      nxt_status[`BSAF_STAT_FC] = 1'b0; // [RULE_09]
    end
    if (cond.allDelivered) begin
      nxt_status[`BSAF_STAT_FD] = 1'b1; // [RULE_10]
    end else if (meas.relativeCharge >= `BSAF_RSOC_FULLDIS) begin
      nxt_status[`BSAF_STAT_FD] = 1'b0; // [RULE_10]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      otaHeld_ff <= 1'b0;
    end else if (clkEn && measTick) begin
      if (meas.temperature > meas.tempMax) begin
        otaHeld_ff <= 1'b1; // [RULE_03]
      end else if (meas.temperature <= otaRelease) begin
        otaHeld_ff <= 1'b0; // [RULE_03]
      end
    end
  end

  // initialized bit: load sets it from the config byte, bad load clears
  always_ff @(posedge clk) begin
    if (rst) begin
      statusWord_ff <= 16'h0000;
    end else if (clkEn) begin
      if (ldState_ff == bsaf_pkg::LdDone) begin
        statusWord_ff[`BSAF_STAT_INIT] <= statByte_ff[`BSAF_INIT_BIT] && !chkFail_ff; // [RULE_07]
      end
      if (measTick) begin
        statusWord_ff[15:8] <= nxt_status[15:8]; // [RULE_22]
        statusWord_ff[6:0] <= nxt_status[6:0]; // [RULE_22]
      end
    end
  end

endmodule

// *** bench/bsaf_cfg_mem.sv ***
// configuration memory model that answers the block's byte reads
`timescale 1ns/1ps
module bsaf_cfg_mem (
  input wire logic clk,
  input wire logic cfgRead,
  input wire logic [6:0] cfgAddr,
  input wire logic badChk,
  output logic [7:0] cfgData = 8'hA5
);
  // distinct high and low bytes so a swapped word shows up
  logic [7:0] mem [0:127] = '{0: 8'h64, 1: 8'h5B, 2: 8'h0A, 4: 8'hF0, 8: 8'h60, 9: 8'h09,
    8'h0C: 8'h80, 8'h0E: 8'h03, 8'h0F: 8'h01, 8'h1A: 8'h34, 8'h1B: 8'h12, 8'h1C: 8'h78,
    8'h1D: 8'h56, 8'h2C: 8'h70, 8'h2D: 8'h17, 8'h2E: 8'h08, default: 8'h00};
  always @(posedge clk) begin
    if (cfgRead) begin
      cfgData <= (cfgAddr == 7'h01 && badChk) ? 8'h5A : mem[cfgAddr];
    end else begin
      cfgData <= ~cfgData; // not driven: never the last value
    end
  end
endmodule

// *** bench/bsaf_battery_status_alarm_flags_checker.sv ***
// assertions on status bits, the overload flag and the capacity clamp pulse
`timescale 1ns/1ps
module bsaf_battery_status_alarm_flags_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic measTick,
  input wire bsaf_pkg::bsaf_cond_t cond,
  input wire bsaf_pkg::bsaf_meas_t meas,
  input wire logic [15:0] statusWord_ff,
  input wire bsaf_pkg::bsaf_param_t param_ff,
  input wire logic overloadFlag_ff,
  input wire logic capacityClampReq_ff,
  input wire logic [15:0] capacityClampValue_ff
);
  // three held ticks cover the one-tick lag of internal flags
  wire logic tk = clkEn && measTick;
  wire logic chg = cond.charging && !cond.discharging;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ovchg_set_a: assert property (
    (tk && chg && (cond.termRate || cond.termTaper))[*3] |=> statusWord_ff[15] && statusWord_ff[14])
    else $error("overcharge alarms not set");
  ovchg_clr_a: assert property (
    (tk && cond.discharging && !cond.charging)[*3] |=> !statusWord_ff[15] && !statusWord_ff[14])
    else $error("charge alarms kept in discharge");
  tchg_set_a: assert property (
    (tk && chg && (cond.overCurrent || cond.overVoltage))[*3] |=> statusWord_ff[14])
    else $error("terminate charge not set");
  otemp_set_a: assert property (
    (tk && meas.temperature > meas.tempMax)[*3] |=> statusWord_ff[12])
    else $error("over temp not set");
  otemp_clr_a: assert property (
    (tk && (meas.temperature <= 16'h01AE || meas.temperature + 16'h0032 <= meas.tempMax))[*3]
    |=> !statusWord_ff[12]) else $error("over temp not cleared");
  tdis_clr_a: assert property (
    (tk && meas.voltage > meas.finalDischargeThreshold)[*3] |=> !statusWord_ff[11])
    else $error("terminate discharge kept");
  capal_set_a: assert property (
    (tk && meas.remainingCapacity < param_ff.capAlarm)[*3] |=> statusWord_ff[9])
    else $error("capacity alarm not set");
  timal_clr_a: assert property (
    (tk && cond.validCharge)[*3] |=> !statusWord_ff[8]) else $error("time alarm kept");
  dsg_clr_a: assert property (
    (tk && cond.charging)[*3] |=> !statusWord_ff[6]) else $error("discharging kept");
  fdis_clr_a: assert property (
    (tk && meas.relativeCharge >= 8'h14)[*3] |=> !statusWord_ff[4]) else $error("fully discharged kept");
  ovl_set_a: assert property (
    (tk && meas.dischargeCurrent > param_ff.overloadLevel)[*3] |=> overloadFlag_ff)
    else $error("overload flag not set");
  clamp_pulse_a: assert property (
    capacityClampReq_ff |-> capacityClampValue_ff == {8'h00, param_ff.lowCapacity} ##1 !capacityClampReq_ff)
    else $error("clamp pulse wrong");
endmodule
bind bsaf_battery_status_alarm_flags bsaf_battery_status_alarm_flags_checker bsaf_battery_status_alarm_flags_checker_i (
  .clk(clk), .rst(rst), .clkEn(clkEn), .measTick(measTick), .cond(cond), .meas(meas),
  .statusWord_ff(statusWord_ff), .param_ff(param_ff), .overloadFlag_ff(overloadFlag_ff),
  .capacityClampReq_ff(capacityClampReq_ff), .capacityClampValue_ff(capacityClampValue_ff));

// *** bench/bsaf_battery_status_alarm_flags_tb.sv ***
// self-checking bench for the status alarm flags block
`timescale 1ns/1ps
module bsaf_battery_status_alarm_flags_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic loadStart = 1'b0;
  logic measTick = 1'b0;
  logic badChk = 1'b0;
  logic clkEn = 1'b1;
  logic loadBusy, loadBad, finalFlag, ovlFlag, clampReq, cfgRead;
  logic [6:0] cfgAddr;
  logic [7:0] cfgData;
  logic [15:0] sw, clampVal;
  bsaf_pkg::bsaf_cond_t cd = 9'h008;
  bsaf_pkg::bsaf_meas_t ms;
  bsaf_pkg::bsaf_param_t prm;
  int miscompares = 0;
  int comparisons = 0;
  int clampSeen = 0;
  always #10 clk = ~clk;
  always @(posedge clk) if (clampReq) clampSeen <= clampSeen + 1;
  bsaf_battery_status_alarm_flags bsaf_battery_status_alarm_flags_i (.clk(clk), .rst(rst), .clkEn(clkEn),
    .loadStart(loadStart), .measTick(measTick), .cond(cd), .meas(ms), .cfgData(cfgData), .cfgAddr_ff(cfgAddr),
    .cfgRead_ff(cfgRead), .statusWord_ff(sw), .param_ff(prm), .loadBusy_ff(loadBusy), .loadBad_ff(loadBad),
    .finalDischargeFlag_ff(finalFlag), .overloadFlag_ff(ovlFlag), .capacityClampReq_ff(clampReq),
    .capacityClampValue_ff(clampVal));
  bsaf_cfg_mem bsaf_cfg_mem_i (.clk(clk), .cfgRead(cfgRead), .cfgAddr(cfgAddr), .badChk(badChk), .cfgData(cfgData));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // a second start mid-load must be ignored, so busy stays low after
  task automatic load(input logic bad);
    int n;
    n = 0;
    badChk <= bad;
    loadStart <= 1'b1;
    @(posedge clk);
    loadStart <= 1'b0;
    repeat (10) @(posedge clk);
    loadStart <= 1'b1;
    @(posedge clk);
    loadStart <= 1'b0;
    while (loadBusy !== 1'b0 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 1000) begin
      miscompares++;
      print_verdict();
    end
    repeat (3) @(posedge clk);
    chk("loadBusy", 16'h0000, loadBusy);
    $display("load done bad %b", loadBad);
  endtask
  task automatic step(input logic [15:0] exp);
    measTick <= 1'b1;
    repeat (5) @(posedge clk);
    measTick <= 1'b0;
    @(posedge clk);
    chk("status", exp, sw);
    $display("step done status %h", sw);
  endtask
  initial begin
    ms = '0;
    ms.voltage = 16'h4000;
    ms.finalDischargeThreshold = 16'h3000;
    ms.firstDischargeThreshold = 16'h3200;
    ms.temperature = 16'h00FA;
    ms.tempMax = 16'h0262;
    ms.remainingCapacity = 16'h0A00;
    ms.fullChargeLevel = 16'h0900;
    ms.timeToEmpty = 16'h0064;
    ms.avgTimeToEmpty = 16'h0064;
    ms.relativeCharge = 8'h32;
    ms.dischargeCurrent = 16'h0100;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("status", 16'h0000, sw);
    load(1'b0);
    chk("loadBad", 16'h0000, loadBad);
    chk("timeAlarm", 16'h000A, prm.timeAlarm);
    chk("capAlarm", 16'h00F0, prm.capAlarm);
    chk("initCharge", 16'h0960, prm.initChargeCurrent);
    chk("fastCharge", 16'h1234, prm.fastChargeCurrent);
    chk("maint", 16'h5678, prm.maintCurrent);
    chk("cycles", 16'h0103, prm.cycleCount);
    chk("overload", 16'h1770, prm.overloadLevel);
    chk("lowCap", 16'h0008, prm.lowCapacity);
    step(16'h00C0);
    cd <= 9'h114;
    step(16'hC0A0);
    cd <= 9'h008;
    step(16'h00E0);
    ms.remainingCapacity <= 16'h00E0;
    ms.timeToEmpty <= 16'h0005;
    ms.avgTimeToEmpty <= 16'h0005;
    step(16'h03C0);
    ms.remainingCapacity <= 16'h0A00;
    ms.timeToEmpty <= 16'h0064;
    ms.avgTimeToEmpty <= 16'h0064;
    ms.temperature <= 16'h0280;
    ms.voltage <= 16'h2F00;
    ms.relativeCharge <= 8'h0A;
    cd <= 9'h009;
    step(16'h18D0);
    chk("finalFlag", 16'h0001, finalFlag);
    ms.temperature <= 16'h0258;
    ms.voltage <= 16'h4000;
    ms.relativeCharge <= 8'h13;
    cd <= 9'h008;
    step(16'h10D0);
    ms.temperature <= 16'h0230;
    ms.relativeCharge <= 8'h14;
    step(16'h00C0);
    chk("finalFlag", 16'h0001, finalFlag);
    cd <= 9'h014;
    step(16'h0080);
    chk("finalFlag", 16'h0000, finalFlag);
    cd <= 9'h008;
    ms.dischargeCurrent <= 16'h1800;
    ms.voltage <= 16'h2F00;
    step(16'h00C0);
    chk("overloadFlag", 16'h0001, ovlFlag);
    chk("finalFlag", 16'h0000, finalFlag);
    cd <= 9'h050;
    ms.dischargeCurrent <= 16'h0100;
    ms.voltage <= 16'h4000;
    step(16'h4080);
    cd <= 9'h008;
    ms.voltage <= 16'h3100;
    step(16'h00C0);
    chk("clampSeen", 16'h0002, 16'(clampSeen));
    chk("clampValue", 16'h0008, clampVal);
    load(1'b1);
    chk("loadBad", 16'h0001, loadBad);
    step(16'h0040);
    // enable low: a charging tick must leave the status word untouched
    clkEn <= 1'b0;
    cd <= 9'h014;
    step(16'h0040);
    clkEn <= 1'b1;
    step(16'h0000);
    print_verdict();
  end
endmodule
